// *** common/port9_mux_pkg.sv ***
package port9_mux_pkg;

    // ----------------------------------------
    // Pin and code layout
    // ----------------------------------------
    localparam int PIN_COUNT = 16;
    // Pins that own a select-extension bit (0-7, 14, 15)
    localparam logic [15:0] EXT_PRESENT_MASK = 16'hc0ff;

    typedef enum logic [1:0] {
        CODE_ADDR = 2'b00,
        CODE_F1 = 2'b01,
        CODE_F2 = 2'b10,
        CODE_F3 = 2'b11
    } func_code_t;

    // ----------------------------------------
    // Peripheral input function indexes
    // ----------------------------------------
    localparam int FIN_COUNT = 20;
    localparam int FIN_KEY6 = 0;
    localparam int FIN_KEY7 = 1;
    localparam int FIN_UART1_RX = 2;
    localparam int FIN_I2C_DATA = 3;
    localparam int FIN_I2C_CLOCK = 4;
    localparam int FIN_T4C1 = 5;
    localparam int FIN_T4C0 = 6;
    localparam int FIN_T3C1 = 7;
    localparam int FIN_T3C0 = 8;
    localparam int FIN_T2C1 = 9;
    localparam int FIN_T2C0 = 10;
    localparam int FIN_S1_DATA = 11;
    localparam int FIN_S1_CLOCK = 12;
    localparam int FIN_S3_DATA = 13;
    localparam int FIN_S3_CLOCK = 14;
    localparam int FIN_INT4 = 15;
    localparam int FIN_INT5 = 16;
    localparam int FIN_INT6 = 17;
    localparam int FIN_T5C1 = 18;
    localparam int FIN_T5C0 = 19;

    // ----------------------------------------
    // Reset and idle values
    // ----------------------------------------
    // Level a deselected input function sees: UART and I2C idle high, rest low
    localparam logic [19:0] FIN_IDLE = 20'h0001c;
    localparam logic [15:0] PIN_OUT_RESET = 16'h0000;
    localparam logic [15:0] PIN_OE_RESET = 16'h0000;
    localparam logic [15:0] PIN_LEVEL_RESET = 16'h0000;
    localparam int SYNC_STAGES = 3;

endpackage

// *** dv/port9_alt_function_mux_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module port9_alt_function_mux_bench import port9_mux_pkg::*;;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] alt = 16'h0000, ext = 16'h0000, sel = 16'h0000, od = 16'h0000;
    logic [15:0] latch = 16'ha5c3, dir = 16'h0ff0, addr = 16'h0000;
    logic [15:0] board = 16'h0000, board_en = 16'hffff, lvl;
    logic [16:0] po = 17'h00000;
    logic [31:0] ep;
    wire [15:0] pin_in, pin_out, pin_oe;
    wire [19:0] fin;
    int num_errors = 0;
    int checks = 0;
    // Each entry is alternate, extension, select, open drain
    // Every entry that selects an I2C line also sets that pin's open-drain bit
    logic [63:0] cfg [7] = '{64'h0000_ffff_ffff_00f0, 64'hffff_0000_0000_0000, 64'hffff_c0ff_dbc2_0002,
        64'hffff_ffff_ffff_0003, 64'hffff_ffff_0000_0000, 64'hffff_0000_ffff_0000, 64'h0f0f_5555_3333_0001};
    logic [16:0] pat [4] = '{17'h05555, 17'h02aaa, 17'h1ffff, 17'h00000};

    port9_alt_function_mux port9_alt_function_mux_inst (
        .SYS_CLK(sys_clk), .RST(rst), .ALT_MODE_SELECT(alt), .FUNC_SELECT(sel), .FUNC_SELECT_EXT(ext),
        .OPEN_DRAIN_CTRL(od), .PORT_LATCH(latch), .PORT_DIR(dir), .ADDR_BUS_OUT(addr),
        .UART1_TRANSMIT_OUT(po[0]), .I2C_DATA_LINE_OUT(po[1]), .I2C_CLOCK_LINE_OUT(po[2]),
        .TIMER4_CH1_OUTPUT(po[3]), .TIMER4_CH0_OUTPUT(po[4]), .TIMER3_CH1_OUTPUT(po[5]),
        .TIMER3_CH0_OUTPUT(po[6]), .TIMER2_CH1_OUTPUT(po[7]), .TIMER2_CH0_OUTPUT(po[8]),
        .TIMER5_CH1_OUTPUT(po[9]), .TIMER5_CH0_OUTPUT(po[10]), .SERIAL1_DATA_OUT(po[11]),
        .SERIAL1_CLOCK_OUT(po[12]), .SERIAL3_DATA_OUT(po[13]), .SERIAL3_CLOCK_OUT(po[14]),
        .SERIAL1_CLOCK_OE(po[15]), .SERIAL3_CLOCK_OE(po[16]),
        .KEY_RETURN_IN_6(fin[FIN_KEY6]), .KEY_RETURN_IN_7(fin[FIN_KEY7]), .UART1_RECEIVE_IN(fin[FIN_UART1_RX]),
        .I2C_DATA_LINE_IN(fin[FIN_I2C_DATA]), .I2C_CLOCK_LINE_IN(fin[FIN_I2C_CLOCK]),
        .TIMER4_CH1_INPUT(fin[FIN_T4C1]), .TIMER4_CH0_INPUT(fin[FIN_T4C0]), .TIMER3_CH1_INPUT(fin[FIN_T3C1]),
        .TIMER3_CH0_INPUT(fin[FIN_T3C0]), .TIMER2_CH1_INPUT(fin[FIN_T2C1]), .TIMER2_CH0_INPUT(fin[FIN_T2C0]),
        .SERIAL1_DATA_IN(fin[FIN_S1_DATA]), .SERIAL1_CLOCK_IN(fin[FIN_S1_CLOCK]),
        .SERIAL3_DATA_IN(fin[FIN_S3_DATA]), .SERIAL3_CLOCK_IN(fin[FIN_S3_CLOCK]),
        .EXT_INTERRUPT_4(fin[FIN_INT4]), .EXT_INTERRUPT_5(fin[FIN_INT5]), .EXT_INTERRUPT_6(fin[FIN_INT6]),
        .TIMER5_CH1_INPUT(fin[FIN_T5C1]), .TIMER5_CH0_INPUT(fin[FIN_T5C0]),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe)
    );

    port9_board_model port9_board_model_inst (
        .pin_out(pin_out), .pin_oe(pin_oe), .board_val(board), .board_en(board_en), .pin_level(pin_in)
    );

    // ----------------------------------------
    // Reference of the pin table
    // ----------------------------------------
    function automatic logic [31:0] exp_pins(input logic [15:0] a, e, s, o, input logic [16:0] p);
        logic [15:0] oe;
        logic [15:0] out;
        logic [1:0] k;
        logic v;
        logic en;
        int x;
        for (int i = 0; i < 16; i++) begin
            k = {e[i] & EXT_PRESENT_MASK[i], s[i]};
            v = addr[i];
            en = 1'b1;
            x = -1;
            if (k != 2'b00) begin
                en = 1'b0;
                case (i)
                    0: x = (k == 2'b10) ? 0 : (k == 2'b11) ? 1 : -1;
                    1: x = (k == 2'b11) ? 2 : -1;
                    2, 3, 4, 5: x = (k == 2'b10) ? i + 1 : -1;
                    6, 7: x = (k == 2'b11) ? i + 1 : -1;
                    14, 15: x = (k == 2'b11) ? i - 5 : -1;
                    8, 9: x = i + 3;
                    11, 12: x = i + 2;
                    default: x = -1;
                endcase
                if (x >= 0) begin
                    v = p[x];
                    en = (i == 9) ? p[15] : (i == 12) ? p[16] : 1'b1;
                end
            end
            if (!a[i]) begin
                v = latch[i];
                en = ~dir[i];
            end
            oe[i] = en & ~(o[i] & v);
            out[i] = v;
        end
        return {oe, out};
    endfunction

    function automatic logic [19:0] exp_fin(input logic [15:0] a, e, s, p);
        logic [19:0] f;
        logic [2:0] k [16];
        f = FIN_IDLE;
        for (int i = 0; i < 16; i++) k[i] = {a[i], e[i] & EXT_PRESENT_MASK[i], s[i]};
        if (k[0] == 3'b101) f[FIN_KEY6] = p[0];
        if (k[0] == 3'b111) f[FIN_I2C_DATA] = p[0];
        if (k[1] == 3'b101 || k[1] == 3'b110) f[FIN_KEY7] = p[1];
        if (k[1] == 3'b110) f[FIN_UART1_RX] = p[1];
        if (k[1] == 3'b111) f[FIN_I2C_CLOCK] = p[1];
        for (int i = 2; i < 6; i++) if (k[i] == 3'b101) f[i + 3] = p[i];
        if (k[6] == 3'b110) f[FIN_T2C1] = p[6];
        if (k[7] == 3'b101) f[FIN_S1_DATA] = p[7];
        if (k[7] == 3'b110) f[FIN_T2C0] = p[7];
        if (k[9] == 3'b101) f[FIN_S1_CLOCK] = p[9];
        if (k[10] == 3'b101) f[FIN_S3_DATA] = p[10];
        if (k[12] == 3'b101) f[FIN_S3_CLOCK] = p[12];
        if (k[13] == 3'b101) f[FIN_INT4] = p[13];
        if (k[14] == 3'b101) f[FIN_INT5] = p[14];
        if (k[15] == 3'b101) f[FIN_INT6] = p[15];
        if (k[14] == 3'b110) f[FIN_T5C1] = p[14];
        if (k[15] == 3'b110) f[FIN_T5C0] = p[15];
        return f;
    endfunction

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Whole run is about 200 cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        num_errors++;
        end_of_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (2) @(negedge sys_clk);
        check("pin_oe_reset", 32'(pin_oe), 32'h0);
        check("fin_reset", 32'(fin), 32'(FIN_IDLE));
        rst = 1'b0;
        for (int c = 0; c < 7; c++) begin
            for (int j = 0; j < 4; j++) begin
                // Whole-register writes; I2C pins get open drain with their code
                {alt, ext, sel, od} = cfg[c];
                po = pat[j];
                board = {po[7:0], ~po[15:8]};
                addr = ~board;
                repeat (6) @(negedge sys_clk);
                ep = exp_pins(alt, ext, sel, od, po);
                lvl = (ep[31:16] & ep[15:0]) | (~ep[31:16] & board);
                check("pin_oe", 32'(pin_oe), 32'(ep[31:16]));
                check("pin_out", 32'(pin_out & ep[31:16]), 32'(ep[15:0] & ep[31:16]));
                // No input is read back here while the mux drives either serial clock
                if (po[16:15] == 2'b00) begin
                    check("fin", 32'(fin), 32'(exp_fin(alt, ext, sel, lvl)));
                end
            end
        end
        {alt, ext, sel, od} = cfg[5];
        board = 16'h0000;
        repeat (6) @(negedge sys_clk);
        check("int5_low", 32'(fin[FIN_INT5]), 32'h0);
        board_en[14] = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("int5_early", 32'(fin[FIN_INT5]), 32'h0);
        repeat (3) @(negedge sys_clk);
        check("int5_high", 32'(fin[FIN_INT5]), 32'h1);
        alt = 16'hbfff;
        repeat (2) @(negedge sys_clk);
        check("int5_idle", 32'(fin[FIN_INT5]), 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire

// *** dv/port9_board_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Board side of the sixteen pins
// ----------------------------------------
module port9_board_model (
    // Pads from the mux
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    // Board drivers, enable high while driving
    input wire logic [15:0] board_val,
    input wire logic [15:0] board_en,
    // Resolved wire level
    output logic [15:0] pin_level
);
    // Undriven pins rise to the pull-up, as the open-drain lines rely on
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & board_en & board_val) | (~pin_oe & ~board_en);
endmodule
`default_nettype wire

// *** rtl/port9_alt_function_mux.sv ***
`timescale 1ns/10ps
`default_nettype none

module port9_alt_function_mux
    import port9_mux_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Pin control bits
    input wire logic [15:0] ALT_MODE_SELECT,
    input wire logic [15:0] FUNC_SELECT,
    input wire logic [15:0] FUNC_SELECT_EXT,
    input wire logic [15:0] OPEN_DRAIN_CTRL,
    // General-purpose port (direction 1 means input)
    input wire logic [15:0] PORT_LATCH,
    input wire logic [15:0] PORT_DIR,
    // External address bus
    input wire logic [15:0] ADDR_BUS_OUT,
    // Peripheral outputs toward pins
    input wire logic UART1_TRANSMIT_OUT,
    input wire logic I2C_DATA_LINE_OUT,
    input wire logic I2C_CLOCK_LINE_OUT,
    input wire logic TIMER4_CH1_OUTPUT,
    input wire logic TIMER4_CH0_OUTPUT,
    input wire logic TIMER3_CH1_OUTPUT,
    input wire logic TIMER3_CH0_OUTPUT,
    input wire logic TIMER2_CH1_OUTPUT,
    input wire logic TIMER2_CH0_OUTPUT,
    input wire logic TIMER5_CH1_OUTPUT,
    input wire logic TIMER5_CH0_OUTPUT,
    input wire logic SERIAL1_DATA_OUT,
    input wire logic SERIAL1_CLOCK_OUT,
    input wire logic SERIAL1_CLOCK_OE,
    input wire logic SERIAL3_DATA_OUT,
    input wire logic SERIAL3_CLOCK_OUT,
    input wire logic SERIAL3_CLOCK_OE,
    // Peripheral inputs from pins
    output logic KEY_RETURN_IN_6,
    output logic KEY_RETURN_IN_7,
    output logic UART1_RECEIVE_IN,
    output logic I2C_DATA_LINE_IN,
    output logic I2C_CLOCK_LINE_IN,
    output logic TIMER4_CH1_INPUT,
    output logic TIMER4_CH0_INPUT,
    output logic TIMER3_CH1_INPUT,
    output logic TIMER3_CH0_INPUT,
    output logic TIMER2_CH1_INPUT,
    output logic TIMER2_CH0_INPUT,
    output logic SERIAL1_DATA_IN,
    output logic SERIAL1_CLOCK_IN,
    output logic SERIAL3_DATA_IN,
    output logic SERIAL3_CLOCK_IN,
    output logic EXT_INTERRUPT_4,
    output logic EXT_INTERRUPT_5,
    output logic EXT_INTERRUPT_6,
    output logic TIMER5_CH1_INPUT,
    output logic TIMER5_CH0_INPUT,
    // Pins
    input wire logic [15:0] PIN_IN,
    output logic [15:0] PIN_OUT,
    output logic [15:0] PIN_OE
);

    // ----------------------------------------
    // Per-pin function code
    // ----------------------------------------
    func_code_t code [PIN_COUNT];
    logic [15:0] alt;
    logic [15:0] alt_val;
    logic [15:0] alt_en;
    logic [15:0] out_next;
    logic [15:0] oe_next;
    logic [15:0] pin_lvl;
    logic [15:0] out_reg;
    logic [15:0] oe_reg;
    logic [FIN_COUNT-1:0] fin_src;
    logic [FIN_COUNT-1:0] fin_sel;
    logic [FIN_COUNT-1:0] fin_next;
    logic [FIN_COUNT-1:0] fin_reg;

    assign alt = ALT_MODE_SELECT;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            // Pins without an extension bit read it as 0
            assign code[i] = func_code_t'({FUNC_SELECT_EXT[i] & EXT_PRESENT_MASK[i], FUNC_SELECT[i]});
            // Alternate mode takes only the function code, never latch or direction
            assign out_next[i] = alt[i] ? alt_val[i] : PORT_LATCH[i];
            // Open drain only ever pulls low; a high level releases the pin
            assign oe_next[i] = (alt[i] ? alt_en[i] : ~PORT_DIR[i])
                & (~OPEN_DRAIN_CTRL[i] | ~out_next[i]);
        end
    endgenerate

    // ----------------------------------------
    // Output selection per pin
    // ----------------------------------------
    assign alt_val[0] = (code[0] == CODE_ADDR) ? ADDR_BUS_OUT[0] :
        (code[0] == CODE_F2) ? UART1_TRANSMIT_OUT : I2C_DATA_LINE_OUT;
    assign alt_en[0] = (code[0] != CODE_F1);
    assign alt_val[1] = (code[1] == CODE_ADDR) ? ADDR_BUS_OUT[1] : I2C_CLOCK_LINE_OUT;
    assign alt_en[1] = (code[1] == CODE_ADDR) || (code[1] == CODE_F3);
    assign alt_val[2] = (code[2] == CODE_ADDR) ? ADDR_BUS_OUT[2] : TIMER4_CH1_OUTPUT;
    assign alt_val[3] = (code[3] == CODE_ADDR) ? ADDR_BUS_OUT[3] : TIMER4_CH0_OUTPUT;
    assign alt_val[4] = (code[4] == CODE_ADDR) ? ADDR_BUS_OUT[4] : TIMER3_CH1_OUTPUT;
    assign alt_val[5] = (code[5] == CODE_ADDR) ? ADDR_BUS_OUT[5] : TIMER3_CH0_OUTPUT;
    generate
        for (i = 2; i < 6; i++) begin : g_timer_en
            assign alt_en[i] = (code[i] == CODE_ADDR) || (code[i] == CODE_F2);
        end
    endgenerate
    assign alt_val[6] = (code[6] == CODE_ADDR) ? ADDR_BUS_OUT[6] : TIMER2_CH1_OUTPUT;
    assign alt_en[6] = (code[6] == CODE_ADDR) || (code[6] == CODE_F3);
    assign alt_val[7] = (code[7] == CODE_ADDR) ? ADDR_BUS_OUT[7] : TIMER2_CH0_OUTPUT;
    assign alt_en[7] = (code[7] == CODE_ADDR) || (code[7] == CODE_F3);
    assign alt_val[8] = (code[8] == CODE_ADDR) ? ADDR_BUS_OUT[8] : SERIAL1_DATA_OUT;
    assign alt_en[8] = 1'b1;
    assign alt_val[9] = (code[9] == CODE_ADDR) ? ADDR_BUS_OUT[9] : SERIAL1_CLOCK_OUT;
    assign alt_en[9] = (code[9] == CODE_ADDR) || SERIAL1_CLOCK_OE;
    assign alt_val[10] = ADDR_BUS_OUT[10];
    assign alt_en[10] = (code[10] == CODE_ADDR);
    assign alt_val[11] = (code[11] == CODE_ADDR) ? ADDR_BUS_OUT[11] : SERIAL3_DATA_OUT;
    assign alt_en[11] = 1'b1;
    assign alt_val[12] = (code[12] == CODE_ADDR) ? ADDR_BUS_OUT[12] : SERIAL3_CLOCK_OUT;
    assign alt_en[12] = (code[12] == CODE_ADDR) || SERIAL3_CLOCK_OE;
    assign alt_val[13] = ADDR_BUS_OUT[13];
    assign alt_en[13] = (code[13] == CODE_ADDR);
    assign alt_val[14] = (code[14] == CODE_ADDR) ? ADDR_BUS_OUT[14] : TIMER5_CH1_OUTPUT;
    assign alt_en[14] = (code[14] == CODE_ADDR) || (code[14] == CODE_F3);
    assign alt_val[15] = (code[15] == CODE_ADDR) ? ADDR_BUS_OUT[15] : TIMER5_CH0_OUTPUT;
    assign alt_en[15] = (code[15] == CODE_ADDR) || (code[15] == CODE_F3);

    // ----------------------------------------
    // Input routing
    // ----------------------------------------
    port9_input_filter #(
        .WIDTH(PIN_COUNT)
    ) u_filter (
        .clk(SYS_CLK),
        .rst(RST),
        .d(PIN_IN),
        .q(pin_lvl)
    );

    // Key return 7 is shared with UART1 receive under code 10; software keeps them apart
    assign fin_src[FIN_KEY6] = pin_lvl[0];
    assign fin_sel[FIN_KEY6] = alt[0] && (code[0] == CODE_F1);
    assign fin_src[FIN_KEY7] = pin_lvl[1];
    assign fin_sel[FIN_KEY7] = alt[1] && ((code[1] == CODE_F1) || (code[1] == CODE_F2));
    assign fin_src[FIN_UART1_RX] = pin_lvl[1];
    assign fin_sel[FIN_UART1_RX] = alt[1] && (code[1] == CODE_F2);
    assign fin_src[FIN_I2C_DATA] = pin_lvl[0];
    assign fin_sel[FIN_I2C_DATA] = alt[0] && (code[0] == CODE_F3);
    assign fin_src[FIN_I2C_CLOCK] = pin_lvl[1];
    assign fin_sel[FIN_I2C_CLOCK] = alt[1] && (code[1] == CODE_F3);
    generate
        for (i = 0; i < 4; i++) begin : g_timer_in
            assign fin_src[FIN_T4C1 + i] = pin_lvl[2 + i];
            assign fin_sel[FIN_T4C1 + i] = alt[2 + i] && (code[2 + i] == CODE_F1);
        end
    endgenerate
    assign fin_src[FIN_T2C1] = pin_lvl[6];
    assign fin_sel[FIN_T2C1] = alt[6] && (code[6] == CODE_F2);
    assign fin_src[FIN_T2C0] = pin_lvl[7];
    assign fin_sel[FIN_T2C0] = alt[7] && (code[7] == CODE_F2);
    assign fin_src[FIN_S1_DATA] = pin_lvl[7];
    assign fin_sel[FIN_S1_DATA] = alt[7] && (code[7] == CODE_F1);
    assign fin_src[FIN_S1_CLOCK] = pin_lvl[9];
    assign fin_sel[FIN_S1_CLOCK] = alt[9] && (code[9] == CODE_F1);
    assign fin_src[FIN_S3_DATA] = pin_lvl[10];
    assign fin_sel[FIN_S3_DATA] = alt[10] && (code[10] == CODE_F1);
    assign fin_src[FIN_S3_CLOCK] = pin_lvl[12];
    assign fin_sel[FIN_S3_CLOCK] = alt[12] && (code[12] == CODE_F1);
    assign fin_src[FIN_INT4] = pin_lvl[13];
    assign fin_sel[FIN_INT4] = alt[13] && (code[13] == CODE_F1);
    assign fin_src[FIN_INT5] = pin_lvl[14];
    assign fin_sel[FIN_INT5] = alt[14] && (code[14] == CODE_F1);
    assign fin_src[FIN_INT6] = pin_lvl[15];
    assign fin_sel[FIN_INT6] = alt[15] && (code[15] == CODE_F1);
    assign fin_src[FIN_T5C1] = pin_lvl[14];
    assign fin_sel[FIN_T5C1] = alt[14] && (code[14] == CODE_F2);
    assign fin_src[FIN_T5C0] = pin_lvl[15];
    assign fin_sel[FIN_T5C0] = alt[15] && (code[15] == CODE_F2);

    // Deselected inputs rest at their idle level so no stray edge reaches a peripheral
    assign fin_next = (fin_sel & fin_src) | (~fin_sel & FIN_IDLE);

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_reg <= PIN_OUT_RESET;
            oe_reg <= PIN_OE_RESET;
            fin_reg <= FIN_IDLE;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            fin_reg <= fin_next;
        end
    end

    assign PIN_OUT = out_reg;
    assign PIN_OE = oe_reg;
    assign KEY_RETURN_IN_6 = fin_reg[FIN_KEY6];
    assign KEY_RETURN_IN_7 = fin_reg[FIN_KEY7];
    assign UART1_RECEIVE_IN = fin_reg[FIN_UART1_RX];
    assign I2C_DATA_LINE_IN = fin_reg[FIN_I2C_DATA];
    assign I2C_CLOCK_LINE_IN = fin_reg[FIN_I2C_CLOCK];
    assign TIMER4_CH1_INPUT = fin_reg[FIN_T4C1];
    assign TIMER4_CH0_INPUT = fin_reg[FIN_T4C0];
    assign TIMER3_CH1_INPUT = fin_reg[FIN_T3C1];
    assign TIMER3_CH0_INPUT = fin_reg[FIN_T3C0];
    assign TIMER2_CH1_INPUT = fin_reg[FIN_T2C1];
    assign TIMER2_CH0_INPUT = fin_reg[FIN_T2C0];
    assign SERIAL1_DATA_IN = fin_reg[FIN_S1_DATA];
    assign SERIAL1_CLOCK_IN = fin_reg[FIN_S1_CLOCK];
    assign SERIAL3_DATA_IN = fin_reg[FIN_S3_DATA];
    assign SERIAL3_CLOCK_IN = fin_reg[FIN_S3_CLOCK];
    assign EXT_INTERRUPT_4 = fin_reg[FIN_INT4];
    assign EXT_INTERRUPT_5 = fin_reg[FIN_INT5];
    assign EXT_INTERRUPT_6 = fin_reg[FIN_INT6];
    assign TIMER5_CH1_INPUT = fin_reg[FIN_T5C1];
    assign TIMER5_CH0_INPUT = fin_reg[FIN_T5C0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_addr_ignores_latch: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[3] && (code[3] == CODE_ADDR) && !OPEN_DRAIN_CTRL[3]
        |=> PIN_OUT[3] == $past(ADDR_BUS_OUT[3]) && PIN_OE[3])
        else $error("pin 3 address mode does not follow address bus");
    a_uart_tx_pin0: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[0] && (code[0] == CODE_F2) |=> PIN_OUT[0] == $past(UART1_TRANSMIT_OUT))
        else $error("pin 0 does not carry UART1 transmit");
    a_key7_shares_rx: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[1] && (code[1] == CODE_F2) |=> KEY_RETURN_IN_7 == UART1_RECEIVE_IN)
        else $error("key return 7 not fed from UART1 receive");
    a_capture_in_pin2: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[2] && (code[2] == CODE_F1) |=> !PIN_OE[2] && TIMER4_CH1_INPUT == $past(pin_lvl[2]))
        else $error("pin 2 capture input routing wrong");
    a_timer2_out_pin6: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[6] && (code[6] == CODE_F3) |=> PIN_OUT[6] == $past(TIMER2_CH1_OUTPUT))
        else $error("pin 6 does not carry timer2 ch1 output");
    a_serial1_in_pin7: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[7] && (code[7] == CODE_F1) |=> SERIAL1_DATA_IN == $past(pin_lvl[7]) && !PIN_OE[7])
        else $error("pin 7 serial1 data input routing wrong");
    a_serial1_out_pin8: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[8] && FUNC_SELECT[8] |=> PIN_OUT[8] == $past(SERIAL1_DATA_OUT))
        else $error("pin 8 does not carry serial1 data output");
    a_int4_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[13] && !FUNC_SELECT[13] |=> EXT_INTERRUPT_4 == FIN_IDLE[FIN_INT4]
        && PIN_OE[13] == $past(~OPEN_DRAIN_CTRL[13] | ~ADDR_BUS_OUT[13]))
        else $error("pin 13 interrupt not isolated in address mode");
    a_int5_pin14: assert property (@(posedge SYS_CLK) disable iff (RST)
        alt[14] && (code[14] == CODE_F1) |=> EXT_INTERRUPT_5 == $past(pin_lvl[14]))
        else $error("pin 14 interrupt 5 routing wrong");
    a_gpio_latch: assert property (@(posedge SYS_CLK) disable iff (RST)
        !alt[5] |=> PIN_OUT[5] == $past(PORT_LATCH[5]) && TIMER3_CH0_INPUT == FIN_IDLE[FIN_T3C0])
        else $error("pin 5 not under port control");
    a_open_drain_low: assert property (@(posedge SYS_CLK) disable iff (RST)
        OPEN_DRAIN_CTRL[0] && out_next[0] |=> !PIN_OE[0])
        else $error("open drain pin 0 driven high");

endmodule

`default_nettype wire

// *** rtl/port9_input_filter.sv ***
`timescale 1ns/10ps
`default_nettype none

module port9_input_filter
    import port9_mux_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("port9_input_filter: WIDTH must be at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_reg;
    logic [WIDTH-1:0] agree;

    // A change counts only once stages two and three agree
    assign agree = ~(s2_reg ^ s3_reg);
    assign q = q_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= (agree & s3_reg) | (~agree & q_reg);
        end
    end

endmodule

`default_nettype wire
